// [hdl/gdw_map.svh]
// Constants for the I/O-line and DAC word decoder
`ifndef GDW_MAP_SVH
`define GDW_MAP_SVH

// Command bytes
`define GDW_CMD_IO_CFG 8'h03
`define GDW_CMD_IO_WR 8'h02
`define GDW_CMD_IO_RD 8'h01
`define GDW_CMD_DAC_SEL 4'h1

// Last bit-counter values of byte and word frames (length minus one)
`define GDW_BYTE_LAST 5'h07
`define GDW_WORD_LAST 5'h0f

// DAC word fields
`define GDW_W_CTL_MSB 15
`define GDW_W_CTL_LSB 12
`define GDW_W_DAT_MSB 11
`define GDW_W_DAT_LSB 2
`define GDW_W_PRESET 11
`define GDW_W_SEL_MSB 7
`define GDW_W_SEL_LSB 4
`define GDW_W_MODE_MSB 3
`define GDW_W_MODE_LSB 1

// DAC control codes
`define GDW_CTL_CLR_PRE 4'h1
`define GDW_CTL_LOAD0 4'h2
`define GDW_CTL_LOAD3 4'h5
`define GDW_CTL_THRU_A 4'ha
`define GDW_CTL_THRU_B 4'hc
`define GDW_CTL_LOAD_ALL 4'hd
`define GDW_CTL_SEL_LOAD 4'he
`define GDW_CTL_POWER 4'hf

// Data byte field of the I/O commands
`define GDW_IO_MSB 7
`define GDW_IO_LSB 4

// Reset and preset values
`define GDW_RST_DIR 4'h0
`define GDW_RST_LVL 4'hf
`define GDW_RST_CODE 10'h000
`define GDW_ALL_ONES 10'h3ff

`endif

// [hdl/gdw_pkg.sv]
// Types shared by the decoder modules
package gdw_pkg;

  // Kind of completed transfer handed to the core
  typedef enum logic [1:0] {
    GDW_K_NONE = 2'b00,
    GDW_K_CFG = 2'b01,
    GDW_K_WR = 2'b10,
    GDW_K_DAC = 2'b11
  } gdw_kind_e;

  // Output buffer state, coded as the power command mode bits
  typedef enum logic [2:0] {
    GDW_BUF_GND100K = 3'b000,
    GDW_BUF_UP = 3'b001,
    GDW_BUF_HIZ = 3'b010,
    GDW_BUF_GND1K = 3'b100,
    GDW_BUF_REF100K = 3'b111
  } gdw_buf_e;

  // Serial link states
  typedef enum logic [2:0] {
    GDW_ST_CMD = 3'b000,
    GDW_ST_BYTE = 3'b001,
    GDW_ST_RD = 3'b010,
    GDW_ST_DAC = 3'b011,
    GDW_ST_SKIP = 3'b100
  } gdw_lstate_e;

endpackage

// [hdl/gdw_link_if.sv]
// Hand-over between the serial-clock side and the core side
`timescale 1ns/1ps
interface gdw_link_if;
  import gdw_pkg::*;
  logic [15:0] word; // Captured data byte or DAC word
  gdw_kind_e kind; // What the word is
  logic done_tgl; // Toggles once per completed transfer

  modport link (output word, output kind, output done_tgl);
  modport core (input word, input kind, input done_tgl);
endinterface

// [hdl/gdw_link.sv]
// Serial-clock side: command decode, data capture, read-back shifting
`timescale 1ns/1ps
`include "gdw_map.svh"
module gdw_link
  import gdw_pkg::*;
(
  // Reset and serial pins
  input wire logic nrst,
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic din,
  output logic dout,
  output logic dout_oe,
  // Raw line levels for read-back
  input wire logic [3:0] io_line_in,
  // Toward the core
  gdw_link_if.link lk
);

  // Frame reset: link state clears while chip select is high
  logic frame_rst_n;
  assign frame_rst_n = nrst & ~cs_n;

  gdw_lstate_e st, next_st; // Link state
  logic [4:0] cnt, next_cnt; // Bit counter
  logic [15:0] sh, next_sh; // Input shifter
  logic [15:0] shin; // Shifter with this edge's bit
  logic [7:0] osh, next_osh; // Read-back shifter
  logic next_dout;
  gdw_kind_e cur, next_cur; // Kind of pending data byte
  logic [15:0] next_word;
  gdw_kind_e next_kind;
  logic next_tgl;
  logic [3:0] io_s1, io_s2; // Pin synchroniser

  // Next-state logic; bits are taken on the falling serial edge
  always_comb
  begin
    shin = {sh[14:0], din};
    next_sh = shin;
    next_cnt = cnt + 5'h01;
    next_st = st;
    next_cur = cur;
    next_osh = {osh[6:0], 1'b0};
    next_dout = osh[7];
    next_word = lk.word;
    next_kind = lk.kind;
    next_tgl = lk.done_tgl;
    case (st)
      GDW_ST_CMD:
        if (cnt == `GDW_BYTE_LAST)
        begin
          next_cnt = 5'h00;
          next_st = GDW_ST_SKIP; // Other registers: rest of frame ignored
          if (shin[7:0] == `GDW_CMD_IO_CFG)
          begin
            next_st = GDW_ST_BYTE;
            next_cur = GDW_K_CFG;
          end
          else if (shin[7:0] == `GDW_CMD_IO_WR)
          begin
            next_st = GDW_ST_BYTE;
            next_cur = GDW_K_WR;
          end
          else if (shin[7:0] == `GDW_CMD_IO_RD)
          begin
            // First data bit (always zero) leaves on this edge
            next_st = GDW_ST_RD;
            next_dout = 1'b0;
            next_osh = {3'h0, io_s2, 1'b0};
          end
          else if (shin[7:4] == `GDW_CMD_DAC_SEL)
            next_st = GDW_ST_DAC;
        end
      GDW_ST_BYTE:
        if (cnt == `GDW_BYTE_LAST)
        begin
          // Only a full byte is handed over; short ones die with the frame
          next_cnt = 5'h00;
          next_st = GDW_ST_CMD;
          next_word = {8'h00, shin[7:0]};
          next_kind = cur;
          next_tgl = ~lk.done_tgl;
        end
      GDW_ST_RD:
        if (cnt == `GDW_BYTE_LAST)
        begin
          next_cnt = 5'h00;
          next_st = GDW_ST_CMD;
        end
      GDW_ST_DAC:
        if (cnt == `GDW_WORD_LAST)
        begin
          // Words cut short never reach this point, so they are dropped
          next_cnt = 5'h00;
          next_st = GDW_ST_CMD;
          next_word = shin;
          next_kind = GDW_K_DAC;
          next_tgl = ~lk.done_tgl;
        end
      GDW_ST_SKIP:
        next_cnt = 5'h00;
      default:
        next_st = GDW_ST_SKIP;
    endcase
  end

  // Frame-scoped state
  always_ff @(negedge sclk or negedge frame_rst_n)
  begin
    if (!frame_rst_n)
    begin
      st <= GDW_ST_CMD;
      cnt <= 5'h00;
      sh <= 16'h0000;
      osh <= 8'h00;
      cur <= GDW_K_NONE;
      dout <= 1'b0;
      dout_oe <= 1'b0;
    end
    else
    begin
      st <= next_st;
      cnt <= next_cnt;
      sh <= next_sh;
      osh <= next_osh;
      cur <= next_cur;
      dout <= next_dout;
      dout_oe <= 1'b1;
    end
  end

  // Hand-over registers survive the end of the frame
  always_ff @(negedge sclk or negedge nrst)
  begin
    if (!nrst)
    begin
      lk.word <= 16'h0000;
      lk.kind <= GDW_K_NONE;
      lk.done_tgl <= 1'b0;
      io_s1 <= 4'h0;
      io_s2 <= 4'h0;
    end
    else
    begin
      lk.word <= next_word;
      lk.kind <= next_kind;
      lk.done_tgl <= next_tgl;
      io_s1 <= io_line_in;
      io_s2 <= io_s1;
    end
  end

endmodule // gdw_link

// [hdl/gdw_decoder.sv]
// Top: serial I/O-line commands and quad DAC word decoder core
//
// Operation
// - Command 03h then byte loads line directions
// - Command 02h then byte loads line levels
// - Command 01h shifts line states out next
// - Select 1Xh then 16-bit word, short dropped
// - Code 1, first bit 0 clears all
// - Code 1, first bit 1 presets all ones
// - Codes 2..5 load one input register
// - Codes Ah, Ch write through all channels
// - Code Dh loads all input registers only
// - Code Eh copies selected input to DAC
// - Unselected channels untouched by selective load
// - Code Fh mode 001 powers up selected
// - Code Fh modes 000, 010, 100, 111 pick power-down termination
// - Unselected channels keep their buffer state
`timescale 1ns/1ps
`include "gdw_map.svh"
module gdw_decoder
  import gdw_pkg::*;
#(
  parameter int CHANNELS = 4, // DAC channel count
  parameter int CODE_W = 10 // DAC code width
)
(
  // Core clock and reset
  input wire logic clk,
  input wire logic nrst,
  // Serial link
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic din,
  output logic dout,
  output logic dout_oe,
  // I/O lines; index 3..0 are io_line_c_high, io_line_c_low,
  // io_line_a_high, io_line_a_low
  input wire logic [3:0] io_line_in,
  output logic [3:0] io_line_out,
  output logic [3:0] io_line_oe,
  // Converter side
  output logic [CHANNELS-1:0][CODE_W-1:0] input_code,
  output logic [CHANNELS-1:0][CODE_W-1:0] dac_code,
  output gdw_buf_e [CHANNELS-1:0] buf_mode
  // Codes and buffer states are levels for the analog side;
  // they change together in one core cycle per command, so the
  // converter never sees a half-applied word
);

  // The block runs in two domains. The serial clock only toggles
  // inside frames, so nothing that must act after the frame ends
  // may live on it: the link captures bytes and words, the core
  // applies them. One toggle per completed transfer carries the
  // news across; the word itself is held steady by the link until
  // the next transfer completes, at least sixteen serial clocks on.
  gdw_link_if lk ();

  // Serial-clock side
  gdw_link u_link (
    .nrst(nrst),
    .sclk(sclk),
    .cs_n(cs_n),
    .din(din),
    .dout(dout),
    .dout_oe(dout_oe),
    .io_line_in(io_line_in),
    .lk(lk.link)
  );

  // Crossing of the completion toggle and of chip select
  logic tgl_s1, tgl_s2, tgl_s3; // Toggle synchroniser and edge tap
  logic cs_s1, cs_s2; // Chip select synchroniser
  logic done_evt; // One cycle per finished transfer

  // The edge detector looks at the second and third stage only
  assign done_evt = tgl_s2 ^ tgl_s3;

  // Line configuration state
  logic [3:0] dir, next_dir; // 1 = driven output
  logic [3:0] lvl, next_lvl; // Written level
  logic [3:0] pend_dir, next_pend_dir; // Byte awaiting frame end
  logic [3:0] pend_lvl, next_pend_lvl;
  logic pend_cfg, next_pend_cfg; // Direction byte waiting
  logic pend_wr, next_pend_wr; // Level byte waiting
  logic [3:0] next_out, next_oe;

  // DAC state
  logic [CHANNELS-1:0][CODE_W-1:0] next_input, next_dac;
  gdw_buf_e [CHANNELS-1:0] next_buf;

  // Fields of the captured word
  logic [3:0] ctl; // Control code
  logic [CODE_W-1:0] dat; // Ten data bits
  logic [3:0] sel; // Channel select, bit i = channel i
  logic [2:0] mode; // Power mode bits
  logic [3:0] io_byte; // Line bits from a data byte

  // Field taps are only meaningful in the cycle done_evt is high;
  // the kind tag tells which layout applies. Reading them at other
  // times is harmless because every use below is gated by the
  // event, so a word changing under the taps does no damage.
  assign ctl = lk.word[`GDW_W_CTL_MSB:`GDW_W_CTL_LSB];
  assign dat = lk.word[`GDW_W_DAT_MSB:`GDW_W_DAT_LSB];
  assign sel = lk.word[`GDW_W_SEL_MSB:`GDW_W_SEL_LSB];
  assign mode = lk.word[`GDW_W_MODE_MSB:`GDW_W_MODE_LSB];
  assign io_byte = lk.word[`GDW_IO_MSB:`GDW_IO_LSB];

  // Toggle crossing rather than a pulse: a pulse from the serial
  // side could be narrower than a core period and be lost, while
  // a level change is always seen. The third stage exists only as
  // the edge tap; nothing reads the first stage except the second.
  // Chip select reset value is high so no commit is seen as a
  // false frame end right after reset.
  // Synchronisers; word and kind are stable for a whole next command,
  // which outlasts the three-stage toggle path at these clock rates
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      tgl_s1 <= 1'b0;
      tgl_s2 <= 1'b0;
      tgl_s3 <= 1'b0;
      cs_s1 <= 1'b1;
      cs_s2 <= 1'b1;
    end
    else
    begin
      tgl_s1 <= lk.done_tgl;
      tgl_s2 <= tgl_s1;
      tgl_s3 <= tgl_s2;
      cs_s1 <= cs_n;
      cs_s2 <= cs_s1;
    end
  end

  // Line setup is two-stage: a finished byte parks in a pending
  // register, and only the synchronised deselect moves it to the
  // live register. A byte that lands while chip select is already
  // high commits one cycle later, never in the same cycle; when the
  // pending flag set and its clear meet, the set wins. The drive
  // enable and value are worked out from the next live values so
  // the pins follow the commit without an extra cycle of lag.
  // Line register next values
  always_comb
  begin
    next_dir = dir;
    next_lvl = lvl;
    next_pend_dir = pend_dir;
    next_pend_lvl = pend_lvl;
    next_pend_cfg = pend_cfg;
    next_pend_wr = pend_wr;
    // Bytes take effect only once chip select has gone high
    if (cs_s2 && pend_cfg)
    begin
      next_dir = pend_dir;
      next_pend_cfg = 1'b0;
    end
    if (cs_s2 && pend_wr)
    begin
      next_lvl = pend_lvl;
      next_pend_wr = 1'b0;
    end
    // A new byte wins over the commit in the same cycle
    if (done_evt && lk.kind == GDW_K_CFG)
    begin
      next_pend_dir = io_byte;
      next_pend_cfg = 1'b1;
    end
    if (done_evt && lk.kind == GDW_K_WR)
    begin
      next_pend_lvl = io_byte;
      next_pend_wr = 1'b1;
    end
    // Pin drive from direction and level
    for (int i = 0; i < 4; i++)
    begin
      next_oe[i] = next_dir[i] | ~next_lvl[i];
      next_out[i] = next_dir[i] & next_lvl[i];
    end
  end

  // Line registers; pin drive resets off so nothing fights the
  // board before the host has set the lines up. Limitation: the
  // pulldown combination drives low, so users must not pair a
  // zero level with zero direction on a line tied to a supply.
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      dir <= `GDW_RST_DIR;
      lvl <= `GDW_RST_LVL; // Lines come up as plain inputs
      pend_dir <= `GDW_RST_DIR;
      pend_lvl <= `GDW_RST_LVL;
      pend_cfg <= 1'b0;
      pend_wr <= 1'b0;
      io_line_out <= 4'h0;
      io_line_oe <= 4'h0;
    end
    else
    begin
      dir <= next_dir;
      lvl <= next_lvl;
      pend_dir <= next_pend_dir;
      pend_lvl <= next_pend_lvl;
      pend_cfg <= next_pend_cfg;
      pend_wr <= next_pend_wr;
      io_line_out <= next_out;
      io_line_oe <= next_oe;
    end
  end

  // All DAC commands act in the single cycle of done_evt. Only the
  // registers a command names are written; the defaults at the top
  // keep everything else, which is what leaves unselected channels
  // and buffer states alone. The clear and preset value is chosen
  // by the first data bit only, the rest of the word is ignored.
  // Power mode bits outside the five defined codes leave a
  // selected buffer as it was rather than guessing a termination.
  // Trade-off: one wide decode instead of per-channel modules.
  // DAC word decode; codes with no command fall through as no-ops
  always_comb
  begin
    next_input = input_code;
    next_dac = dac_code;
    next_buf = buf_mode;
    if (done_evt && lk.kind == GDW_K_DAC)
    begin
      case (ctl)
        `GDW_CTL_CLR_PRE:
          for (int i = 0; i < CHANNELS; i++)
          begin
            // Buffers are left in their present state
            next_input[i] = lk.word[`GDW_W_PRESET] ?
              CODE_W'(`GDW_ALL_ONES) : CODE_W'(`GDW_RST_CODE);
            next_dac[i] = next_input[i];
          end
        `GDW_CTL_THRU_A, `GDW_CTL_THRU_B:
          for (int i = 0; i < CHANNELS; i++)
          begin
            next_input[i] = dat;
            next_dac[i] = dat;
          end
        `GDW_CTL_LOAD_ALL:
          for (int i = 0; i < CHANNELS; i++)
            next_input[i] = dat;
        `GDW_CTL_SEL_LOAD:
          for (int i = 0; i < CHANNELS; i++)
            if (sel[i])
              next_dac[i] = input_code[i];
            else
              next_dac[i] = dac_code[i];
        `GDW_CTL_POWER:
          for (int i = 0; i < CHANNELS; i++)
            if (sel[i])
            begin
              case (mode)
                GDW_BUF_UP: next_buf[i] = GDW_BUF_UP;
                GDW_BUF_HIZ: next_buf[i] = GDW_BUF_HIZ;
                GDW_BUF_GND1K: next_buf[i] = GDW_BUF_GND1K;
                GDW_BUF_GND100K: next_buf[i] = GDW_BUF_GND100K;
                GDW_BUF_REF100K: next_buf[i] = GDW_BUF_REF100K;
                default: next_buf[i] = buf_mode[i]; // Undefined mode
              endcase
            end
            else
              next_buf[i] = buf_mode[i];
        default:
          // Single-channel loads, outputs unchanged
          if (ctl >= `GDW_CTL_LOAD0 && ctl <= `GDW_CTL_LOAD3)
            next_input[2'(ctl - `GDW_CTL_LOAD0)] = dat;
      endcase
    end
  end

  // DAC registers; all codes start at zero scale and every buffer
  // starts disconnected with the weak pull to ground, so the
  // outputs sit at a known low level until the host powers them.
  // The reset branch loads constants only; the loop is unrolled
  // over the channel count.
  // DAC registers
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      for (int i = 0; i < CHANNELS; i++)
      begin
        input_code[i] <= CODE_W'(`GDW_RST_CODE);
        dac_code[i] <= CODE_W'(`GDW_RST_CODE);
        buf_mode[i] <= GDW_BUF_GND100K; // Powered down at start
      end
    end
    else
    begin
      input_code <= next_input;
      dac_code <= next_dac;
      buf_mode <= next_buf;
    end
  end

endmodule // gdw_decoder

// [verif/gdw_decoder_chk.sv]
// Port checker for the I/O-line and DAC word decoder
`timescale 1ns/1ps
module gdw_decoder_chk
  import gdw_pkg::*;
#(
  parameter int CHANNELS = 4, // DAC channel count
  parameter int CODE_W = 10 // DAC code width
)
(
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // Serial link
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic din,
  input wire logic dout,
  input wire logic dout_oe,
  // I/O lines
  input wire logic [3:0] io_line_in,
  input wire logic [3:0] io_line_out,
  input wire logic [3:0] io_line_oe,
  // Converter side
  input wire logic [CHANNELS-1:0][CODE_W-1:0] input_code,
  input wire logic [CHANNELS-1:0][CODE_W-1:0] dac_code,
  input wire gdw_buf_e [CHANNELS-1:0] buf_mode
);
  logic [4:0] fall_cnt; // Falls seen in this frame

  // Count falls; deselect clears at once, like the link
  always_ff @(negedge sclk or posedge cs_n or negedge nrst)
  begin
    if (!nrst || cs_n)
      fall_cnt <= 5'h00;
    else if (fall_cnt != 5'h1f)
      fall_cnt <= fall_cnt + 5'h01;
  end

  property p_idle_quiet;
    @(posedge clk) disable iff (!nrst) cs_n [*2] |-> !dout && !dout_oe;
  endproperty
  a_idle_quiet: assert property (p_idle_quiet)
    else $error("serial output active while deselected");

  property p_cmd_zero;
    @(negedge sclk) disable iff (!nrst || cs_n) fall_cnt <= 5'h08 |-> !dout;
  endproperty
  a_cmd_zero: assert property (p_cmd_zero)
    else $error("output not zero during command byte");

  property p_oe_frame;
    @(negedge sclk) disable iff (!nrst || cs_n)
    fall_cnt >= 5'h02 |-> dout_oe;
  endproperty
  a_oe_frame: assert property (p_oe_frame)
    else $error("serial output not enabled in frame");

  // Line setup may only land after deselect
  property p_dir_hold;
    @(posedge clk) disable iff (!nrst) !cs_n [*8] |-> $stable(io_line_oe);
  endproperty
  a_dir_hold: assert property (p_dir_hold)
    else $error("line enable changed inside a frame");

  property p_lvl_hold;
    @(posedge clk) disable iff (!nrst) !cs_n [*8] |-> $stable(io_line_out);
  endproperty
  a_lvl_hold: assert property (p_lvl_hold)
    else $error("line level changed inside a frame");

  property p_dac_quiet;
    @(posedge clk) disable iff (!nrst) cs_n [*8] |->
      $stable(dac_code) && $stable(input_code) && $stable(buf_mode);
  endproperty
  a_dac_quiet: assert property (p_dac_quiet)
    else $error("converter state changed with no word");

  property p_buf_alone;
    @(posedge clk) disable iff (!nrst)
    $changed(buf_mode) |-> $stable(input_code) && $stable(dac_code);
  endproperty
  a_buf_alone: assert property (p_buf_alone)
    else $error("power command touched codes");

  property p_code_alone;
    @(posedge clk) disable iff (!nrst)
    $changed(input_code) |-> $stable(buf_mode);
  endproperty
  a_code_alone: assert property (p_code_alone)
    else $error("code load touched buffers");

  // Per channel: a DAC register only ever takes its input value
  for (genvar g = 0; g < CHANNELS; g++)
  begin : g_ch
    property p_dac_from_in;
      @(posedge clk) disable iff (!nrst)
      $changed(dac_code[g]) |-> dac_code[g] == input_code[g];
    endproperty
    a_dac_from_in: assert property (p_dac_from_in)
      else $error("DAC register differs from input register");

    property p_buf_legal;
      @(posedge clk) disable iff (!nrst)
      buf_mode[g] inside {3'h0, 3'h1, 3'h2, 3'h4, 3'h7};
    endproperty
    a_buf_legal: assert property (p_buf_legal)
      else $error("buffer state outside the five modes");
  end

  // Main traffic seen
  c_io: cover property (@(posedge clk) $changed(io_line_oe));
  c_dac: cover property (@(posedge clk) $changed(dac_code));
  c_buf: cover property (@(posedge clk) $changed(buf_mode));
endmodule // gdw_decoder_chk

bind gdw_decoder gdw_decoder_chk #(.CHANNELS(CHANNELS), .CODE_W(CODE_W))
  i_chk (.clk(clk), .nrst(nrst), .sclk(sclk), .cs_n(cs_n), .din(din),
  .dout(dout), .dout_oe(dout_oe), .io_line_in(io_line_in),
  .io_line_out(io_line_out), .io_line_oe(io_line_oe),
  .input_code(input_code), .dac_code(dac_code), .buf_mode(buf_mode));

// [verif/gdw_host.sv]
// Serial host model: chip select, 6 ns link clock, data
`timescale 1ns/1ps
module gdw_host
(
  // Serial pins
  output logic sclk,
  output logic cs_n,
  output logic din,
  input wire logic dout
);
  // Deselected, clock parked low outside frames
  initial
  begin
    sclk = 1'b0;
    cs_n = 1'b1;
    din = 1'b0;
  end

  // Send n bits of v MSB first; rd keeps last byte taken on rises
  task automatic xfer(input logic [31:0] v, input int n, input bit slow,
    output logic [7:0] rd);
    rd = 8'h00;
    cs_n = 1'b0;
    #7;
    for (int i = n - 1; i >= 0; i--)
    begin
      din = v[i];
      #2 sclk = 1'b1;
      rd = {rd[6:0], dout};
      #3 sclk = 1'b0;
      #1;
      // Slow host stalls with the clock low
      if (slow)
        #9;
    end
    din = ~din; // No stale level after release
    #3 cs_n = 1'b1;
  endtask
endmodule // gdw_host

// [verif/gdw_decoder_bench.sv]
// Self-checking bench for the I/O-line and DAC word decoder
`timescale 1ns/1ps
module gdw_decoder_bench;
  logic clk = 1'b0; // Core clock
  logic nrst = 1'b0; // Reset, active low
  logic [3:0] io_line_in = 4'h0; // Pin levels
  wire logic sclk, cs_n, din; // From host model
  logic dout, dout_oe;
  logic [3:0] io_line_out, io_line_oe;
  logic [3:0][9:0] input_code, dac_code;
  logic [11:0] buf_bits; // Buffer states, packed
  logic [3:0] e_dir = 4'h0, e_lvl = 4'hf; // Expected line setup
  logic [3:0][9:0] e_in = '0, e_dac = '0; // Expected codes
  logic [3:0][2:0] e_buf = '0; // Expected buffers
  logic [31:0] seed = 32'h21c2, r;
  logic [15:0] w;
  logic [7:0] rd;
  int err_total = 0, check_count = 0, cyc = 0;

  gdw_decoder i_gdw_decoder (.clk(clk), .nrst(nrst), .sclk(sclk),
    .cs_n(cs_n), .din(din), .dout(dout), .dout_oe(dout_oe),
    .io_line_in(io_line_in), .io_line_out(io_line_out),
    .io_line_oe(io_line_oe), .input_code(input_code),
    .dac_code(dac_code), .buf_mode(buf_bits));
  gdw_host i_host (.sclk(sclk), .cs_n(cs_n), .din(din), .dout(dout));

  always #10 clk = ~clk;

  // Hang guard, far above the few thousand cycles needed
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      err_total++;
      stop_test();
    end
  end

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  // Expected effect of one DAC word
  function automatic void dac_apply(input logic [15:0] v);
    case (v[15:12])
      4'h1:
      begin
        e_in = {4{v[11] ? 10'h3ff : 10'h000}};
        e_dac = e_in;
      end
      4'h2, 4'h3, 4'h4, 4'h5: e_in[v[13:12] - 2'h2] = v[11:2];
      4'ha, 4'hc:
      begin
        e_in = {4{v[11:2]}};
        e_dac = e_in;
      end
      4'hd: e_in = {4{v[11:2]}};
      4'he:
        for (int i = 0; i < 4; i++)
          if (v[4 + i])
            e_dac[i] = e_in[i];
      4'hf:
        if (v[3:1] inside {3'h0, 3'h1, 3'h2, 3'h4, 3'h7})
          for (int i = 0; i < 4; i++)
            if (v[4 + i])
              e_buf[i] = v[3:1];
      default: ; // No-op codes
    endcase
  endfunction

  task automatic cmp(input logic [39:0] got, input logic [39:0] exp);
    check_count++;
    if (got !== exp)
    begin
      err_total++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Leave time for the crossing and commit
  task automatic settle();
    repeat (10) @(posedge clk);
    #1;
  endtask

  task automatic chk_io();
    logic [3:0] e_oe;
    e_oe = e_dir | ~e_lvl;
    cmp(40'(io_line_oe), 40'(e_oe));
    cmp(40'(io_line_out & e_oe), 40'(e_dir & e_lvl));
  endtask

  task automatic chk_dac();
    cmp(input_code, e_in);
    cmp(dac_code, e_dac);
    cmp(40'(buf_bits), 40'(e_buf));
  endtask

  task automatic stop_test();
    if (err_total == 0 && check_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  initial
  begin
    repeat (4) @(posedge clk);
    nrst <= 1'b1;
    settle();
    chk_io();
    chk_dac();
    // Line setup; first pass hits all four drive combinations
    for (int k = 0; k < 12; k++)
    begin
      r = (k == 0) ? 32'h0000a0c0 : rnd();
      if (k[0])
        i_host.xfer({8'h03, r[7:0], 8'h02, r[15:8]}, 32, r[20], rd);
      else
      begin
        i_host.xfer({24'h3, r[7:0]}, 16, r[20], rd);
        settle();
        i_host.xfer({24'h2, r[15:8]}, 16, r[20], rd);
      end
      e_dir = r[7:4];
      e_lvl = r[15:12];
      settle();
      chk_io();
    end
    // Setup byte cut short is dropped
    i_host.xfer({20'h0, 8'h03, 4'h5}, 12, 1'b0, rd);
    settle();
    chk_io();
    // Read back random pin levels
    for (int k = 0; k < 6; k++)
    begin
      r = rnd();
      @(posedge clk);
      io_line_in <= r[3:0];
      repeat (2) @(posedge clk);
      i_host.xfer({16'h0, 8'h01, r[15:8]}, 16, r[4], rd);
      cmp(40'(rd), 40'(r[3:0]));
      settle();
    end
    // Every control code twice, then power commands alternating with random words
    for (int k = 0; k < 48; k++)
    begin
      r = rnd();
      w = r[15:0];
      if (k < 32)
        w[15:11] = {k[3:0], k[4]};
      if (k == 15)
        w[3:1] = 3'h1;
      if (k >= 32 && k[0])
        w[15:12] = 4'hf;
      i_host.xfer({8'h0, 4'h1, r[19:16], w}, 24, r[20], rd);
      dac_apply(w);
      settle();
      chk_dac();
    end
    // Write-through word cut short is dropped
    i_host.xfer({12'h0, 8'h10, 12'hac3}, 20, 1'b0, rd);
    settle();
    chk_dac();
    stop_test();
  end
endmodule // gdw_decoder_bench
